// ==== dpa_defines.svh ====
// Register offsets, field positions, reset values and timing counts for the DDS control block
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH

// Register byte offsets on the Wishbone bus
`define DPA_OFF_CONTROL_FUNCTION_REG_ONE 8'h00
`define DPA_OFF_FTW 8'h04
`define DPA_OFF_POW 8'h08
`define DPA_OFF_ASF 8'h0C
`define DPA_OFF_ARR 8'h10
`define DPA_OFF_STAT 8'h14

// Control function register one, bit positions
`define DPA_CFR_LOADTMR 26
`define DPA_CFR_KEYEN 25
`define DPA_CFR_KEYSEL 24
`define DPA_CFR_AUTOCLR 13
`define DPA_CFR_CONTCLR 10
`define DPA_CFR_MASK 32'h0700_2400

// Field widths
`define DPA_FTW_W 32
`define DPA_POW_W 14
`define DPA_SCL_W 14
`define DPA_ASF_W 16
`define DPA_ARR_W 8

// Amplitude scale register fields
`define DPA_ASF_STEP_HI 15
`define DPA_ASF_STEP_LO 14
`define DPA_ASF_MAX_HI 13

// Reset values
`define DPA_CONTROL_FUNCTION_REG_ONE_RST 32'h0000_0000
`define DPA_FTW_RST 32'h0000_0000
`define DPA_POW_RST 14'h0000
`define DPA_ASF_RST 16'h0000
`define DPA_ARR_RST 8'h00

// Sync clock divider: system clock divided by four
`define DPA_DIV_W 2
`define DPA_DIV_RISE 2'h1

`endif

// ==== dpa_pkg.sv ====
// Types for the DDS phase and amplitude control block
package dpa_pkg;
`include "dpa_defines.svh"

    // Keying mode, Gray coded along off -> manual -> auto
    typedef enum logic [1:0] {
        DPA_KEY_OFF = 2'b00,
        DPA_KEY_MANUAL = 2'b01,
        DPA_KEY_AUTO = 2'b11
    } dpa_key_t;

    // Complete state of the block
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [31:0] cfr_buf;
        logic [`DPA_FTW_W-1:0] ftw_buf;
        logic [`DPA_POW_W-1:0] pow_buf;
        logic [`DPA_ASF_W-1:0] asf_buf;
        logic [`DPA_ARR_W-1:0] arr_buf;
        logic [31:0] cfr_act;
        logic [`DPA_FTW_W-1:0] ftw_act;
        logic [`DPA_POW_W-1:0] pow_act;
        logic [`DPA_ASF_W-1:0] asf_act;
        logic [`DPA_ARR_W-1:0] arr_act;
        logic [`DPA_DIV_W-1:0] div;
        logic sync_clk;
        logic upd_s1;
        logic upd_s2;
        logic upd_samp;
        logic load;
        logic key_s1;
        logic key_s2;
        logic key_prev;
        dpa_key_t mode;
        logic [`DPA_ARR_W-1:0] ramp_cnt;
        logic [`DPA_SCL_W-1:0] scale;
        logic [`DPA_FTW_W-1:0] acc;
        logic [`DPA_POW_W-1:0] phase;
        logic [`DPA_SCL_W-1:0] sample;
    } dpa_state_t;

endpackage

// ==== dpa_core.sv ====
// DDS phase accumulator, phase offset, shaped keying and update strobe control
`timescale 1ns/1ps

// Widths used in the port list below; offsets, field positions and counts used in the logic
`include "dpa_defines.svh"

// Limitations a user must know:
// - Register reads return the buffered values, not the active ones; the status register returns the live mode and scale
// - Active values change only on the load pulse from the update pin
// - The update pin must fall for one sync period to re-arm the pulse
// - A ramp rate of zero behaves as a rate of one
module dpa_core
    import dpa_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins from the host
    input wire logic reg_update_i,
    input wire logic keying_direction_input_i,
    // Core sample to scale, signed, same clock
    input wire logic [`DPA_SCL_W-1:0] core_sample_i,
    // Outputs
    output logic sync_clk_o,
    output logic [`DPA_POW_W-1:0] phase_o,
    output logic [`DPA_SCL_W-1:0] scale_o,
    output logic [`DPA_SCL_W-1:0] sample_o,
    output logic load_pulse_o
);
    import dpa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and helpers

    dpa_state_t s_reg; // Registered state
    dpa_state_t s_next; // Next state
    logic req; // New bus request
    logic sync_rise; // Sync clock rising edge enable
    logic key_change; // Keying pin toggled
    logic tmr_reload; // Forced ramp timer reload
    logic tick; // Ramp timer expiry
    logic [`DPA_SCL_W-1:0] step; // Auto step size
    logic [`DPA_SCL_W-1:0] max_scl; // Auto ceiling
    logic [`DPA_SCL_W:0] up_sum; // Widened increment
    logic [`DPA_SCL_W-1:0] act_scale; // Scale in use
    logic signed [28:0] prod; // Sample times scale

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_next = s_reg;
        req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
        step = '0;
        max_scl = s_reg.asf_act[`DPA_ASF_MAX_HI:0];
        up_sum = '0;
        act_scale = '0;
        prod = '0;

        // Bus answer: ack one cycle after request, dropped next cycle
        s_next.ack = req;
        s_next.dat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `DPA_OFF_CONTROL_FUNCTION_REG_ONE: s_next.dat = s_reg.cfr_buf;
                `DPA_OFF_FTW: s_next.dat = s_reg.ftw_buf;
                `DPA_OFF_POW: s_next.dat = {18'h00000, s_reg.pow_buf};
                `DPA_OFF_ASF: s_next.dat = {16'h0000, s_reg.asf_buf};
                `DPA_OFF_ARR: s_next.dat = {24'h000000, s_reg.arr_buf};
                `DPA_OFF_STAT: s_next.dat = {14'h0000, s_reg.mode, 2'h0, s_reg.scale};
                default: s_next.dat = 32'h0000_0000;
            endcase
        end
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                `DPA_OFF_CONTROL_FUNCTION_REG_ONE: begin
                    s_next.cfr_buf = merge(s_reg.cfr_buf, wb_dat_i, wb_sel_i) & `DPA_CFR_MASK;
                end
                `DPA_OFF_FTW: s_next.ftw_buf = merge(s_reg.ftw_buf, wb_dat_i, wb_sel_i);
                `DPA_OFF_POW: begin
                    s_next.pow_buf = 14'(merge({18'h0, s_reg.pow_buf}, wb_dat_i, wb_sel_i));
                end
                `DPA_OFF_ASF: begin
                    s_next.asf_buf = 16'(merge({16'h0, s_reg.asf_buf}, wb_dat_i, wb_sel_i));
                end
                `DPA_OFF_ARR: begin
                    s_next.arr_buf = 8'(merge({24'h0, s_reg.arr_buf}, wb_dat_i, wb_sel_i));
                end
                default: ; // Unmapped or read-only: write ignored
            endcase
        end

        // divide-by-four sync clock, high in counts 2 and 3
        // Free-running divider: the sync phase is fixed after reset, so
        // update latency relative to the system clock stays constant
        s_next.div = s_reg.div + 2'h1;
        s_next.sync_clk = s_next.div[1];
        sync_rise = (s_reg.div == `DPA_DIV_RISE);

        // Two-flop synchronisers for the pins
        // Only the second flop feeds logic; the first may be metastable
        s_next.upd_s1 = reg_update_i;
        s_next.upd_s2 = s_reg.upd_s1;
        s_next.key_s1 = keying_direction_input_i;
        s_next.key_s2 = s_reg.key_s1;
        s_next.key_prev = s_reg.key_s2;
        key_change = s_reg.key_s2 ^ s_reg.key_prev;

        // sample on sync rising edge, single pulse per assertion
        s_next.load = 1'b0;
        if (sync_rise) begin
            s_next.upd_samp = s_reg.upd_s2;
            s_next.load = s_reg.upd_s2 & ~s_reg.upd_samp;
        end

        // copy buffers into active registers on the pulse
        if (s_reg.load) begin
            s_next.cfr_act = s_reg.cfr_buf;
            s_next.ftw_act = s_reg.ftw_buf;
            s_next.pow_act = s_reg.pow_buf;
            s_next.asf_act = s_reg.asf_buf;
            s_next.arr_act = s_reg.arr_buf;
        end

        // continuous clear first, then auto clear, then accumulate
        if (s_reg.cfr_act[`DPA_CFR_CONTCLR]) begin
            // held at zero while the bit is set
            s_next.acc = '0;
        end else if (s_reg.load && s_reg.cfr_buf[`DPA_CFR_AUTOCLR]) begin
            // clear for one cycle, then release
            s_next.acc = '0;
        end else begin
            // tuning word added every cycle, no reset on update
            s_next.acc = s_reg.acc + s_reg.ftw_act;
        end

        // offset added to top accumulator bits, linear in angle
        s_next.phase = s_reg.acc[`DPA_FTW_W-1 -: `DPA_POW_W] + s_reg.pow_act;

        // mode from enable and select; select ignored when disabled
        if (!s_reg.cfr_act[`DPA_CFR_KEYEN]) begin
            s_next.mode = DPA_KEY_OFF;
        end else if (s_reg.cfr_act[`DPA_CFR_KEYSEL]) begin
            s_next.mode = DPA_KEY_AUTO;
        end else begin
            s_next.mode = DPA_KEY_MANUAL;
        end

        // forced ramp timer reloads
        // Pin change, update with load bit, or entry into auto mode
        tmr_reload = key_change
                   | (s_reg.load & s_reg.cfr_buf[`DPA_CFR_LOADTMR])
                   | ((s_next.mode == DPA_KEY_AUTO) & (s_reg.mode != DPA_KEY_AUTO));
        tick = 1'b0;
        if (s_reg.mode == DPA_KEY_AUTO) begin
            if (tmr_reload) begin
                s_next.ramp_cnt = s_reg.arr_act;
            end else if (s_reg.ramp_cnt <= 8'h01) begin
                // reload on reaching 1 and tick the scale counter
                s_next.ramp_cnt = s_reg.arr_act;
                tick = 1'b1;
            end else begin
                s_next.ramp_cnt = s_reg.ramp_cnt - 8'h01;
            end
        end else if (tmr_reload) begin
            s_next.ramp_cnt = s_reg.arr_act;
        end

        // step size from the two top bits
        step = 14'h0001 << s_reg.asf_act[`DPA_ASF_STEP_HI:`DPA_ASF_STEP_LO];
        up_sum = {1'b0, s_reg.scale} + {1'b0, step};
        if (s_reg.mode == DPA_KEY_AUTO) begin
            if (s_reg.scale > max_scl) begin
                // ceiling lowered: pull back to it
                s_next.scale = max_scl;
            end else if (tick && s_reg.key_s2) begin
                s_next.scale = (up_sum > {1'b0, max_scl}) ? max_scl : up_sum[`DPA_SCL_W-1:0];
            end else if (tick) begin
                s_next.scale = (s_reg.scale < step) ? 14'h0000 : s_reg.scale - step;
            end
        end

        // manual mode takes the register directly
        unique case (s_reg.mode)
            DPA_KEY_AUTO: act_scale = s_reg.scale;
            DPA_KEY_MANUAL: act_scale = max_scl;
            default: act_scale = 14'h3FFF;
        endcase

        // unsigned scale times signed sample, full scale near unity
        prod = $signed(core_sample_i) * $signed({1'b0, act_scale});
        if (s_reg.mode == DPA_KEY_OFF) begin
            s_next.sample = core_sample_i;
        end else begin
            s_next.sample = prod[27:14];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '{ack: 1'b0, dat: 32'h0000_0000,
                       cfr_buf: `DPA_CONTROL_FUNCTION_REG_ONE_RST, ftw_buf: `DPA_FTW_RST,
                       pow_buf: `DPA_POW_RST, asf_buf: `DPA_ASF_RST,
                       arr_buf: `DPA_ARR_RST, cfr_act: `DPA_CONTROL_FUNCTION_REG_ONE_RST,
                       ftw_act: `DPA_FTW_RST, pow_act: `DPA_POW_RST,
                       asf_act: `DPA_ASF_RST, arr_act: `DPA_ARR_RST,
                       div: 2'h0, sync_clk: 1'b0, upd_s1: 1'b0, upd_s2: 1'b0,
                       upd_samp: 1'b0, load: 1'b0, key_s1: 1'b0, key_s2: 1'b0,
                       key_prev: 1'b0, mode: DPA_KEY_OFF, ramp_cnt: 8'h00,
                       scale: 14'h0000, acc: 32'h0000_0000, phase: 14'h0000,
                       sample: 14'h0000};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Outputs straight from flops, no logic after the state register
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
    assign sync_clk_o = s_reg.sync_clk;
    assign phase_o = s_reg.phase;
    assign scale_o = s_reg.scale;
    assign sample_o = s_reg.sample;
    assign load_pulse_o = s_reg.load;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_sync_div_four: assert property (sync_clk_o && !$past(sync_clk_o) |=> sync_clk_o ##1 !sync_clk_o ##1 !sync_clk_o ##1 sync_clk_o)
        else $error("sync clock is not system clock over four");
    a_load_single: assert property (load_pulse_o |=> !load_pulse_o [*4])
        else $error("update load pulse repeated");
    a_buffer_copy: assert property (load_pulse_o |=> s_reg.ftw_act == $past(s_reg.ftw_buf))
        else $error("active tuning word not copied on load");
    a_active_hold: assert property (!load_pulse_o |=> $stable(s_reg.ftw_act))
        else $error("active tuning word changed without load");
    a_cont_clear: assert property (s_reg.cfr_act[`DPA_CFR_CONTCLR] |=> s_reg.acc == 32'h0)
        else $error("accumulator not held at zero");
    a_auto_clear: assert property (load_pulse_o && s_reg.cfr_buf[`DPA_CFR_AUTOCLR] |=> s_reg.acc == 32'h0)
        else $error("auto clear missed on update");
    a_phase_cont: assert property (load_pulse_o && !s_reg.cfr_buf[`DPA_CFR_AUTOCLR] && !s_reg.cfr_act[`DPA_CFR_CONTCLR] |=> s_reg.acc == $past(s_reg.acc) + $past(s_reg.ftw_act))
        else $error("phase jumped on update");
    a_phase_offset: assert property (##1 phase_o == $past(s_reg.acc[31:18]) + $past(s_reg.pow_act))
        else $error("phase offset not applied");
    a_bypass_off: assert property (s_reg.mode == DPA_KEY_OFF |=> sample_o == $past(core_sample_i))
        else $error("scaling not bypassed while keying off");
    a_scale_ceiling: assert property (s_reg.mode == DPA_KEY_AUTO && $past(s_reg.mode) == DPA_KEY_AUTO && $stable(s_reg.asf_act) && scale_o <= s_reg.asf_act[13:0] |=> scale_o <= s_reg.asf_act[13:0])
        else $error("auto scale above ceiling");
    a_ramp_reload: assert property (s_reg.mode == DPA_KEY_AUTO && key_change |=> s_reg.ramp_cnt == $past(s_reg.arr_act))
        else $error("ramp timer not reloaded on pin change");
    a_auto_entry: assert property (s_reg.mode != DPA_KEY_AUTO && s_next.mode == DPA_KEY_AUTO |=> s_reg.ramp_cnt == $past(s_reg.arr_act))
        else $error("ramp timer not reloaded on auto entry");

    // update with load bit reloads timer
    a_timer_load: assert property (s_reg.load && s_reg.cfr_buf[`DPA_CFR_LOADTMR] |=>
        s_reg.ramp_cnt == $past(s_reg.arr_act))
        else $error("ramp timer not reloaded on update");
    a_ramp_tick: assert property (s_reg.mode == DPA_KEY_AUTO && !tmr_reload &&
        s_reg.ramp_cnt <= 8'h01 |=> s_reg.ramp_cnt == $past(s_reg.arr_act))
        else $error("ramp timer not reloaded at one");
    a_timer_idle: assert property (s_reg.mode != DPA_KEY_AUTO && !tmr_reload |=>
        $stable(s_reg.ramp_cnt))
        else $error("ramp timer moved outside auto mode");
    a_mode_auto: assert property (s_reg.cfr_act[`DPA_CFR_KEYEN] &&
        s_reg.cfr_act[`DPA_CFR_KEYSEL] |=> s_reg.mode == DPA_KEY_AUTO)
        else $error("auto keying mode not entered");
    a_mode_off: assert property (!s_reg.cfr_act[`DPA_CFR_KEYEN] |=>
        s_reg.mode == DPA_KEY_OFF)
        else $error("keying not off while disabled");
    a_scale_frozen: assert property (s_reg.mode != DPA_KEY_AUTO |=>
        $stable(scale_o))
        else $error("scale counter moved outside auto mode");

    // Main scenarios reached by the bench, except c_update: its strobes never give two loads within 8 cycles

    c_update: cover property (load_pulse_o ##[1:8] load_pulse_o);
    c_ramp_up: cover property (s_reg.mode == DPA_KEY_AUTO && s_reg.key_s2 && scale_o == s_reg.asf_act[13:0]);
    c_ramp_down: cover property (s_reg.mode == DPA_KEY_AUTO && !s_reg.key_s2 && $fell(|scale_o));
    c_manual: cover property (s_reg.mode == DPA_KEY_MANUAL && sample_o != 14'h0000);

endmodule

// ==== dpa_host_model.sv ====
// Host model that drives the update strobe and the keying pin
`timescale 1ns/1ps
module dpa_host_model (
    // Clocks from the device side
    input wire logic clk_i,
    input wire logic sync_clk_i,
    // Keying level asked for by the bench
    input wire logic key_req_i,
    // Pins into the device
    output logic reg_update_o,
    output logic keying_direction_o
);
    // Update pin idles low at start
    initial begin
        reg_update_o = 1'b0;
    end
    // Keying pin follows the request one cycle late
    always @(posedge clk_i) begin
        keying_direction_o <= key_req_i;
    end
    // Update strobe, high for hi sync periods
    task automatic pulse_update(input int hi, output logic ok);
        int n;
        logic p;
        p = 1'b1;
        ok = 1'b0;
        // launch just after a sync rise
        for (n = 0; n < 9 && !ok; n++) begin
            @(posedge clk_i);
            ok = (p === 1'b0) && (sync_clk_i === 1'b1);
            p = sync_clk_i;
        end
        reg_update_o <= 1'b1;
        repeat (4 * hi) @(posedge clk_i);
        reg_update_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the DDS phase and amplitude control block
`timescale 1ns/1ps
module tb_top;
    import dpa_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, key_req, upd, key, ack, sync_clk, load;
    logic dchk, hit, sprev, sseen;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, v;
    logic [13:0] smp_in, phase, scale, smp_out, p, f, step, pprev;
    int seed, failures, checks, loads, l0, i, n, r, m, scnt;

    dpa_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .reg_update_i(upd), .keying_direction_input_i(key),
        .core_sample_i(smp_in), .sync_clk_o(sync_clk), .phase_o(phase), .scale_o(scale),
        .sample_o(smp_out), .load_pulse_o(load));
    dpa_host_model i_host (.clk_i(clk_i), .sync_clk_i(sync_clk), .key_req_i(key_req),
        .reg_update_o(upd), .keying_direction_o(key));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and stop
    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One classic bus cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 20) begin
            failures++;
            end_sim();
        end
        @(posedge clk_i);
    endtask
    // Update strobe through the host
    task automatic strobe(input int hi);
        logic ok;
        i_host.pulse_update(hi, ok);
        if (ok !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask
    // Expected scaled sample
    function automatic logic [13:0] scl(input logic [13:0] s, input logic [13:0] k,
                                         input bit en);
        int a;
        a = $signed(s);
        if (!en) return s;
        return 14'((a * int'(k)) >>> 14);
    endfunction
    // Ramp the auto scale to one bound and check each step
    task automatic ramp(input bit up, input int st, input int rr, input int mx);
        int k, gap, nch, pv, ex;
        pv = scale;
        gap = 0;
        nch = 0;
        key_req <= up;
        for (k = 0; k < 600 && scale !== 14'(up ? mx : 0); k++) begin
            @(posedge clk_i);
            gap++;
            if (scale !== 14'(pv)) begin
                ex = up ? ((pv + st > mx) ? mx : pv + st) : ((pv < st) ? 0 : pv - st);
                chk(scale, ex); // step in the pin's direction
                if (nch > 0) chk(gap, rr); // one step per ramp period
                nch++;
                gap = 0;
                pv = scale;
            end
        end
        if (k == 600) begin
            failures++;
            end_sim();
        end
        repeat (3 * rr) @(posedge clk_i);
        chk(scale, up ? mx : 0); // held at the bound
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitors: load pulses, phase steps, sync period
    always @(posedge clk_i) begin
        if (load === 1'b1) loads++;
        if (dchk) chk(14'(phase - pprev), step); // steady phase step
        pprev = phase;
        if (!rst_i && sync_clk === 1'b1 && sprev === 1'b0) begin
            if (sseen) chk(scnt, 4); // clock over four
            sseen = 1'b1;
            scnt = 0;
        end
        scnt++;
        sprev = sync_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 26317;
        {rst_i, cyc, stb, we, key_req, dchk, sprev, sseen} = 8'h80;
        {adr, sel, wdat, smp_in} = '0;
        {failures, checks, loads, scnt} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values and an unmapped place
        for (i = 0; i < 7; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0, 4'hF, q);
            chk(q, 32'h0); // cleared at reset
        end
        $display("test reset done");
        // Buffered writes and update strobe
        v = $random(seed);
        wb(1'b1, 8'h04, v, 4'hF, q);
        wb(1'b1, 8'h04, ~v, 4'h3, q);
        wb(1'b0, 8'h04, 32'h0, 4'hF, q);
        chk(q, {v[31:16], ~v[15:0]}); // lanes merge in buffer
        p = 14'($random(seed));
        wb(1'b1, 8'h08, 32'(p), 4'hF, q);
        wb(1'b1, 8'h00, 32'h0000_0400, 4'hF, q);
        chk(phase, 14'h0); // nothing active yet
        l0 = loads;
        strobe(1);
        chk(loads - l0, 1); // one load per strobe
        @(posedge clk_i);
        chk(phase, p); // held at the offset
        strobe(3);
        chk(loads - l0, 2); // long strobe loads once
        chk(phase, p); // still held
        $display("test buffer done");
        // Tuning step and phase continuity
        step = 14'($random(seed)) | 14'h1;
        wb(1'b1, 8'h04, {step, 18'h0}, 4'hF, q);
        wb(1'b1, 8'h00, 32'h0, 4'hF, q);
        strobe(1);
        dchk <= 1'b1;
        wb(1'b1, 8'h04, $random(seed), 4'hF, q);
        repeat (6) @(posedge clk_i);
        wb(1'b1, 8'h04, {step, 18'h0}, 4'hF, q);
        strobe(1);
        dchk <= 1'b0;
        $display("test tuning done");
        // Auto clear on each strobe, then both clears
        wb(1'b1, 8'h00, 32'h0000_2000, 4'hF, q);
        repeat (2) begin
            hit = 1'b0;
            fork
                strobe(1);
                for (n = 0; n < 24; n++) begin
                    @(posedge clk_i);
                    if (phase === p) hit = 1'b1;
                end
            join
            chk(hit, 1'b1); // accumulator cleared
        end
        wb(1'b1, 8'h00, 32'h0000_2400, 4'hF, q);
        strobe(1);
        chk(phase, p); // continuous clear wins
        $display("test clear done");
        // Keying off and manual scale
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            f = (i == 1) ? 14'h0 : (i == 2) ? 14'h3FFF : v[13:0];
            smp_in <= v[29:16];
            wb(1'b1, 8'h0C, {16'h0, v[31:30], f}, 4'hF, q);
            wb(1'b1, 8'h00, (i == 0) ? 32'h0 : 32'h0200_0000, 4'hF, q);
            strobe(1);
            chk(smp_out, scl(v[29:16], f, i != 0)); // scaled output
            wb(1'b0, 8'h14, 32'h0, 4'hF, q);
            chk(q[17:16], (i == 0) ? 2'b00 : 2'b01); // mode off or manual
        end
        $display("test manual done");
        // Auto ramps for every step code
        for (i = 0; i < 4; i++) begin
            r = 2 + ($random(seed) & 3);
            m = 20 + ($random(seed) & 31);
            wb(1'b1, 8'h10, 32'(r), 4'hF, q);
            wb(1'b1, 8'h0C, {16'h0, 2'(i), 14'(m)}, 4'hF, q);
            wb(1'b1, 8'h00, i[0] ? 32'h0700_0000 : 32'h0300_0000, 4'hF, q);
            strobe(1);
            ramp(1'b1, 1 << i, r, m);
            ramp(1'b0, 1 << i, r, m);
        end
        wb(1'b0, 8'h14, 32'h0, 4'hF, q);
        chk(q[17:16], 2'b11); // mode auto
        $display("test auto done");
        end_sim();
    end
endmodule
